// File: hdl/dss_sram_port.sv
module dss_sram_port
   import dss_pkg::*;
(
   input  wire logic                           clk_i,                    // 200 MHz clock
   input  wire logic                           rstn_i,                   // Async reset, low
   input  wire logic                           k_i,                      // Positive input clock
   input  wire logic                           k_n_i,                    // Negative input clock
   input  wire logic                           c_i,                      // Positive output clock
   input  wire logic                           c_n_i,                    // Negative output clock
   input  wire logic                           single_clk_i,             // Single clock mode
   input  wire logic                           load_strobe_n_i,          // Access strobe, low
   input  wire logic                           rd_not_wr_i,              // High read, low write
   input  wire logic [dss_pkg::DSS_ADDR_W-1:0] addr_i,                   // Shared address
   input  wire logic [dss_pkg::DSS_DATA_W-1:0] wdata_i,                  // Write data
   input  wire logic [dss_pkg::DSS_LANES-1:0]  byte_lane_write_mask_n_i, // Lane masks, low
   output logic      [dss_pkg::DSS_DATA_W-1:0] q_o,                      // Read data
   output logic                                q_oe_o,                   // Read data enable
   output logic                                echo_clock_o,             // Echo clock
   output logic                                echo_clock_n_o            // Echo clock, inverted
);
   import dss_pkg::*;

   // ****************************************
   // Pin synchronisers and edge detect
   // ****************************************
   dss_pins_s pins_now;
   dss_pins_s s1_r;
   dss_pins_s s2_r;
   dss_pins_s s3_r;
   logic      k_rise;
   logic      kn_rise;
   logic      launch0;
   logic      launch1;

   // Pins bundled so all bits share one delay
   always_comb
   begin
      pins_now.k          = k_i;
      pins_now.k_n        = k_n_i;
      pins_now.c          = c_i;
      pins_now.c_n        = c_n_i;
      pins_now.single_clk = single_clk_i;
      pins_now.load_n     = load_strobe_n_i;
      pins_now.rd_not_wr  = rd_not_wr_i;
      pins_now.addr       = addr_i;
      pins_now.wdata      = wdata_i;
      pins_now.mask_n     = byte_lane_write_mask_n_i;
   end

   // Two-stage synchroniser plus edge history
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= pins_now;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Rising edges of the clock pairs
   assign k_rise  = s2_r.k & ~s3_r.k;
   assign kn_rise = s2_r.k_n & ~s3_r.k_n;
   assign launch0 = s2_r.single_clk ? k_rise : (s2_r.c & ~s3_r.c);
   assign launch1 = s2_r.single_clk ? kn_rise : (s2_r.c_n & ~s3_r.c_n);

   // ****************************************
   // Access decode
   // ****************************************
   logic                  start_rd;
   logic                  start_wr;
   logic                  wr_open_r;
   logic [DSS_ADDR_W-1:0] wr_addr_r;
   logic [DSS_DATA_W-1:0] wr_beat0_r;
   logic [DSS_LANES-1:0]  wr_mask0_r;
   logic                  rd_pend_r;
   logic [DSS_ADDR_W-1:0] rd_addr_r;

   assign start_rd = k_rise & ~s2_r.load_n & s2_r.rd_not_wr;
   assign start_wr = k_rise & ~s2_r.load_n & ~s2_r.rd_not_wr;

   // Write address and first beat on positive clock rise
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_addr_r  <= '0;
         wr_beat0_r <= '0;
         wr_mask0_r <= '1;
      end
      else if (start_wr)
      begin
         wr_addr_r  <= s2_r.addr;
         wr_beat0_r <= s2_r.wdata;
         wr_mask0_r <= s2_r.mask_n;
      end
   end

   // Write burst open until the second beat
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_open_r <= 1'b0;
      end
      else if (start_wr)
      begin
         wr_open_r <= 1'b1;
      end
      else if (kn_rise)
      begin
         wr_open_r <= 1'b0;
      end
   end

   // ****************************************
   // Memory access
   // ****************************************
   logic                        mem_we;
   logic [2*DSS_LANES-1:0]      mem_lane;
   logic [DSS_PAIR_W-1:0]       mem_wdata;
   logic                        mem_re;
   logic                        mem_rvalid_r;
   logic [DSS_PAIR_W-1:0]       mem_rdata;
   logic [1:0]                  cnt_r;
   logic                        space_ok;

   // Commit the pair once the second beat is in
   assign mem_we    = wr_open_r & kn_rise;
   assign mem_lane  = ~{s2_r.mask_n, wr_mask0_r};
   assign mem_wdata = {s2_r.wdata, wr_beat0_r};
   assign space_ok  = ({1'b0, cnt_r} + {2'h0, mem_rvalid_r}) < {1'b0, DSS_CNT_FULL};
   assign mem_re    = rd_pend_r & space_ok;

   // Read request waits for buffer room
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= '0;
      end
      else if (start_rd)
      begin
         rd_pend_r <= 1'b1;
         rd_addr_r <= s2_r.addr;
      end
      else if (mem_re)
      begin
         rd_pend_r <= 1'b0;
      end
   end

   // Read data valid one cycle after the strobe
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mem_rvalid_r <= 1'b0;
      end
      else
      begin
         mem_rvalid_r <= mem_re;
      end
   end

   dss_pair_mem #(
      .ADDR_W (DSS_ADDR_W),
      .LANE_W (DSS_LANE_W),
      .NLANES (2*DSS_LANES)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .lane_i  (mem_lane),
      .waddr_i (wr_addr_r),
      .wdata_i (mem_wdata),
      .re_i    (mem_re),
      .raddr_i (rd_addr_r),
      .rdata_o (mem_rdata)
   );

   // ****************************************
   // Two-entry read buffer
   // ****************************************
   dss_pair_s buf_r [DSS_BUF_DEPTH];
   logic      wptr_r;
   logic      rptr_r;
   logic      in_ready;
   logic      out_valid;
   logic      out_ready;
   logic      push;
   logic      pop;
   logic      beat1_pend_r;

   assign in_ready  = cnt_r != DSS_CNT_FULL;
   assign out_valid = cnt_r != DSS_CNT_RST;
   assign out_ready = launch0 & ~beat1_pend_r;
   assign push      = mem_rvalid_r & in_ready;
   assign pop       = out_valid & out_ready;

   // Buffer storage
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         buf_r[wptr_r] <= mem_rdata;
      end
   end

   // Buffer pointers and fill count
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         cnt_r  <= DSS_CNT_RST;
      end
      else
      begin
         wptr_r <= wptr_r ^ push;
         rptr_r <= rptr_r ^ pop;
         cnt_r  <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // ****************************************
   // Read data launch
   // ****************************************
   logic [DSS_DATA_W-1:0] q_r;
   logic [DSS_DATA_W-1:0] hold_r;
   logic                  q_oe_r;

   // Beat 0 on first launch edge, beat 1 on second
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         q_r          <= '0;
         hold_r       <= '0;
         q_oe_r       <= 1'b0;
         beat1_pend_r <= 1'b0;
      end
      else if (pop)
      begin
         q_r          <= buf_r[rptr_r].beat0;
         hold_r       <= buf_r[rptr_r].beat1;
         q_oe_r       <= 1'b1;
         beat1_pend_r <= 1'b1;
      end
      else if (launch1 && beat1_pend_r)
      begin
         q_r          <= hold_r;
         beat1_pend_r <= 1'b0;
      end
      else if (launch0 && !beat1_pend_r)
      begin
         q_oe_r       <= 1'b0;
      end
   end

   // Echo clocks follow the launching clock pair
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         echo_clock_o   <= 1'b0;
         echo_clock_n_o <= 1'b0;
      end
      else
      begin
         echo_clock_o   <= s2_r.single_clk ? s2_r.k : s2_r.c;
         echo_clock_n_o <= s2_r.single_clk ? s2_r.k_n : s2_r.c_n;
      end
   end

   assign q_o    = q_r;
   assign q_oe_o = q_oe_r;

   // ****************************************
   // Checks
   // ****************************************
   chk_lane_commit: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_open_r && kn_rise) |-> (mem_we && mem_lane == ~{s2_r.mask_n, wr_mask0_r}))
      else $error("write pair not committed with lane masks");

   chk_addr_capture: assert property (@(posedge clk_i) disable iff (!rstn_i)
      start_wr |=> (wr_addr_r == $past(s2_r.addr) && wr_open_r))
      else $error("write address not captured");

   chk_addr_ignore: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (k_rise && s2_r.load_n) |=> ($stable(wr_addr_r) && $stable(rd_addr_r)))
      else $error("address taken while deselected");

   chk_read_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
      start_rd |=> (rd_pend_r || mem_rvalid_r) ##0 (rd_addr_r == $past(s2_r.addr)))
      else $error("read not started on direction high");

   chk_read_float: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (launch0 && !beat1_pend_r && !out_valid) |=> !q_oe_o)
      else $error("read data driven while deselected");

   chk_beat1_launch: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (launch1 && beat1_pend_r && !pop) |=> (q_oe_o && q_o == $past(hold_r)))
      else $error("second beat not launched");

   chk_beat0_launch: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pop |=> (q_oe_o && beat1_pend_r && q_o == $past(buf_r[rptr_r].beat0)))
      else $error("first beat not launched");

   chk_buf_room: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (mem_rvalid_r |-> in_ready) and (cnt_r <= DSS_CNT_FULL))
      else $error("read buffer overrun");

   chk_echo_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ##1 (echo_clock_o == ($past(s2_r.single_clk) ? $past(s2_r.k) : $past(s2_r.c))))
      else $error("echo clock does not follow its source");

   chk_read_issue: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rd_pend_r && cnt_r == DSS_CNT_RST && !mem_rvalid_r) |-> mem_re ##1 mem_rvalid_r)
      else $error("read not issued with free buffer");
endmodule

// File: common/dss_pkg.sv
package dss_pkg;
   // ****************************************
   // Widths of the 36-bit organisation
   // ****************************************
   localparam int DSS_ADDR_W = 19;
   localparam int DSS_LANE_W = 9;
   localparam int DSS_LANES  = 4;
   localparam int DSS_DATA_W = DSS_LANE_W * DSS_LANES;
   localparam int DSS_PAIR_W = 2 * DSS_DATA_W;
   localparam int DSS_BUF_DEPTH = 2;
   localparam logic [1:0] DSS_CNT_RST = 2'h0;
   localparam logic [1:0] DSS_CNT_FULL = 2'h2;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic                  k;
      logic                  k_n;
      logic                  c;
      logic                  c_n;
      logic                  single_clk;
      logic                  load_n;
      logic                  rd_not_wr;
      logic [DSS_ADDR_W-1:0] addr;
      logic [DSS_DATA_W-1:0] wdata;
      logic [DSS_LANES-1:0]  mask_n;
   } dss_pins_s;

   typedef struct packed {
      logic [DSS_DATA_W-1:0] beat1;
      logic [DSS_DATA_W-1:0] beat0;
   } dss_pair_s;
endpackage

// File: hdl/dss_pair_mem.sv
// Word-pair memory: low half is array 0, high half is array 1
module dss_pair_mem #(
   parameter int ADDR_W = 19,
   parameter int LANE_W = 9,
   parameter int NLANES = 8
) (
   input  wire logic                       clk_i,   // System clock
   input  wire logic                       we_i,    // Write strobe
   input  wire logic [NLANES-1:0]          lane_i,  // Lane write enables
   input  wire logic [ADDR_W-1:0]          waddr_i, // Write address
   input  wire logic [NLANES*LANE_W-1:0]   wdata_i, // Write pair
   input  wire logic                       re_i,    // Read strobe
   input  wire logic [ADDR_W-1:0]          raddr_i, // Read address
   output logic      [NLANES*LANE_W-1:0]   rdata_o  // Registered read pair
);
   logic [NLANES*LANE_W-1:0] mem_r [2**ADDR_W];

   // Per-lane write, untouched lanes keep old contents
   for (genvar g = 0; g < NLANES; g++)
   begin : g_lane
      always_ff @(posedge clk_i)
      begin
         if (we_i && lane_i[g])
         begin
            mem_r[waddr_i][g*LANE_W +: LANE_W] <= wdata_i[g*LANE_W +: LANE_W];
         end
      end

      // Masked lane keeps its old contents, even when never written
      chk_lane_keep: assert property (@(posedge clk_i)
         (we_i && !lane_i[g]) |=> (mem_r[$past(waddr_i)][g*LANE_W +: LANE_W]
            === $past(mem_r[waddr_i][g*LANE_W +: LANE_W])))
         else $error("masked lane overwritten");

      // Enabled lane takes the write data of its beat
      chk_lane_store: assert property (@(posedge clk_i)
         (we_i && lane_i[g]) |=> (mem_r[$past(waddr_i)][g*LANE_W +: LANE_W]
            == $past(wdata_i[g*LANE_W +: LANE_W])))
         else $error("enabled lane not stored");
   end

   // Registered read of both arrays at once
   always_ff @(posedge clk_i)
   begin
      if (re_i)
      begin
         rdata_o <= mem_r[raddr_i];
      end
   end
endmodule

// File: bench/dss_ctl.sv
// ****************************************
// Memory controller model
// ****************************************
module dss_ctl
   import dss_pkg::*;
(
   input  wire logic                           clk_i,    // System clock
   input  wire logic                           rstn_i,   // Reset, low
   input  wire logic                           single_i, // Single clock mode
   input  wire logic [3:0]                     skew_i,   // Output clock lag
   input  wire logic [dss_pkg::DSS_DATA_W-1:0] q_i,      // Read data
   input  wire logic                           q_oe_i,   // Read data enable
   input  wire logic                           echo_i,   // Echo clock
   input  wire logic                           echo_n_i, // Echo clock, inverted
   output dss_pkg::dss_pins_s                  pins_o    // Pins to the port
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0]            ph_r = 4'h0;
   logic                  ld_n = 1'b1;
   logic                  rd_r = 1'b0;
   logic [DSS_ADDR_W-1:0] a_r  = '0;
   logic [DSS_DATA_W-1:0] d_r  = '0;
   logic [DSS_LANES-1:0]  m_r  = '1;
   logic [DSS_DATA_W-1:0] b0_r;
   logic                  b0_ok = 1'b0;
   logic [3:0]            rph;
   logic                  k_w;
   logic                  c_w;
   int                    up = 0;
   int                    echo_errs = 0;
   dss_pair_s             got_q[$];

   // Free-running clocks, 16 clk cycles a period; output clocks low in single mode
   always @(posedge clk_i) ph_r <= #1 ph_r + 4'h1;
   assign k_w = (ph_r < 4'h8);
   assign c_w = (4'(ph_r - skew_i) < 4'h8);
   assign pins_o = '{k: k_w, k_n: ~k_w, c: c_w & ~single_i, c_n: ~c_w & ~single_i,
                     single_clk: single_i, load_n: ld_n, rd_not_wr: rd_r,
                     addr: a_r, wdata: d_r, mask_n: m_r};

   task automatic wait_ph(input logic [3:0] p);
      @(posedge clk_i);
      while (ph_r !== p) @(posedge clk_i);
      #1;
   endtask

   // Access: strobe, address and beat 0 ahead of K, beat 1 ahead of K#
   task automatic access(input logic l, input logic r, input logic [DSS_ADDR_W-1:0] a,
                         input logic [DSS_DATA_W-1:0] d0, input logic [DSS_DATA_W-1:0] d1,
                         input logic [DSS_LANES-1:0] m0, input logic [DSS_LANES-1:0] m1);
      wait_ph(4'hb);
      ld_n = l;
      rd_r = r;
      a_r = a;
      d_r = d0;
      m_r = m0;
      wait_ph(4'h3);
      d_r = d1;
      m_r = m1;
   endtask

   // Release: strobe high, other lines inverted
   task automatic idle();
      wait_ph(4'hb);
      ld_n = 1'b1;
      rd_r = ~rd_r;
      a_r = ~a_r;
      d_r = ~d_r;
      m_r = ~m_r;
   endtask

   // Capture of read pairs and echo check against the launch clock
   always @(negedge clk_i)
   begin
      up = rstn_i ? up + 1 : 0;
      rph = single_i ? 4'h0 : skew_i;
      if (up > 32 && ph_r == 4'(rph + 4'h6))
      begin
         if (echo_i !== 1'b1 || echo_n_i !== 1'b0) echo_errs++;
         b0_ok = (q_oe_i === 1'b1);
         b0_r = q_i;
      end
      if (up > 32 && ph_r == 4'(rph + 4'he))
      begin
         if (echo_i !== 1'b0 || echo_n_i !== 1'b1) echo_errs++;
         if (b0_ok && q_oe_i === 1'b1) got_q.push_back('{beat1: q_i, beat0: b0_r});
         b0_ok = 1'b0;
      end
   end
endmodule

// File: bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dss_pkg::*;
   typedef logic [DSS_PAIR_W-1:0] dss_cmp_t;
   typedef struct packed {
      logic [DSS_ADDR_W-1:0] a;
      logic [DSS_DATA_W-1:0] d0;
      logic [DSS_DATA_W-1:0] d1;
      logic [DSS_LANES-1:0]  m0;
      logic [DSS_LANES-1:0]  m1;
   } dss_row_s;
   logic                  clk_i = 1'b0;
   logic                  rstn_i = 1'b0;
   logic                  single = 1'b0;
   logic [3:0]            skew = 4'h0;
   dss_pins_s             pins;
   logic [DSS_DATA_W-1:0] q;
   logic                  q_oe;
   logic                  echo;
   logic                  echo_n;
   int                    num_errors = 0;
   int                    checks = 0;
   int                    cycles = 0;
   dss_pair_s             shadow [logic [DSS_ADDR_W-1:0]];
   dss_pair_s             exp_q[$];
   logic [DSS_ADDR_W-1:0] addrs [3] = '{19'h00000, 19'h7ffff, 19'h12345};
   dss_row_s              rows [8] = '{
      '{19'h00000, 36'h111111111, 36'h222222222, 4'h0, 4'h0},
      '{19'h7ffff, 36'h333333333, 36'h444444444, 4'h0, 4'h0},
      '{19'h12345, 36'h555555555, 36'h666666666, 4'h0, 4'h0},
      '{19'h00000, 36'haaaaaaaaa, 36'hbbbbbbbbb, 4'he, 4'h7},
      '{19'h7ffff, 36'hccccccccc, 36'hddddddddd, 4'hd, 4'hb},
      '{19'h12345, 36'heeeeeeeee, 36'h0f0f0f0f0, 4'hf, 4'h0},
      '{19'h00000, 36'h987654321, 36'h13579bdf0, 4'h7, 4'he},
      '{19'h12345, 36'h2468ace02, 36'hfedcba987, 4'hb, 4'hd}};

   always #2.5 clk_i = ~clk_i;

   dss_ctl u_dss_ctl (.clk_i(clk_i), .rstn_i(rstn_i), .single_i(single), .skew_i(skew),
      .q_i(q), .q_oe_i(q_oe), .echo_i(echo), .echo_n_i(echo_n), .pins_o(pins));
   dss_sram_port u_dss_sram_port (.clk_i(clk_i), .rstn_i(rstn_i), .k_i(pins.k),
      .k_n_i(pins.k_n), .c_i(pins.c), .c_n_i(pins.c_n), .single_clk_i(pins.single_clk),
      .load_strobe_n_i(pins.load_n), .rd_not_wr_i(pins.rd_not_wr), .addr_i(pins.addr),
      .wdata_i(pins.wdata), .byte_lane_write_mask_n_i(pins.mask_n), .q_o(q),
      .q_oe_o(q_oe), .echo_clock_o(echo), .echo_clock_n_o(echo_n));

   task automatic end_sim();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input dss_cmp_t e, input dss_cmp_t g);
      checks++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         num_errors++;
      end
   endtask

   // Write, with lanes kept in the expected image only where the mask is low
   task automatic wr(input dss_row_s r);
      int lo;
      u_dss_ctl.access(1'b0, 1'b0, r.a, r.d0, r.d1, r.m0, r.m1);
      for (int n = 0; n < DSS_LANES; n++)
      begin
         lo = n * DSS_LANE_W;
         if (!r.m0[n]) shadow[r.a].beat0[lo +: DSS_LANE_W] = r.d0[lo +: DSS_LANE_W];
         if (!r.m1[n]) shadow[r.a].beat1[lo +: DSS_LANE_W] = r.d1[lo +: DSS_LANE_W];
      end
   endtask

   // Read with live data and open masks on the write lines, which must not write
   task automatic rd(input logic [DSS_ADDR_W-1:0] a);
      u_dss_ctl.access(1'b0, 1'b1, a, '0, '0, '0, '0);
      exp_q.push_back(shadow[a]);
   endtask

   task automatic drain();
      dss_pair_s g;
      u_dss_ctl.idle();
      repeat (80) @(posedge clk_i);
      #1;
      chk("read count", dss_cmp_t'(exp_q.size()), dss_cmp_t'(u_dss_ctl.got_q.size()));
      while (exp_q.size() > 0)
      begin
         g = (u_dss_ctl.got_q.size() > 0) ? u_dss_ctl.got_q.pop_front() : 'x;
         chk("read pair", exp_q.pop_front(), g);
      end
      u_dss_ctl.got_q.delete();
      chk("read enable idle", '0, dss_cmp_t'(q_oe));
   endtask

   // Cycle ceiling against hangs
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         end_sim();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      repeat (8) @(posedge clk_i);
      // Row table: full and masked writes back to back, then reads of every word
      foreach (rows[i]) wr(rows[i]);
      foreach (addrs[i]) rd(addrs[i]);
      drain();
      // Write and read alternating on one word
      wr('{19'h00abc, 36'h123456789, 36'h0fedcba98, 4'h0, 4'h0});
      rd(19'h00abc);
      wr('{19'h00abc, 36'h000000000, 36'hfffffffff, 4'h5, 4'ha});
      rd(19'h00abc);
      drain();
      // Strobe high: address, direction and data ignored
      u_dss_ctl.access(1'b1, 1'b0, 19'h00abc, '1, '1, '0, '0);
      u_dss_ctl.access(1'b1, 1'b1, 19'h00abc, '0, '0, '0, '0);
      rd(19'h00abc);
      drain();
      // Output clocks lagging the input clocks
      skew = 4'h3;
      foreach (addrs[i]) rd(addrs[i]);
      drain();
      // Single clock mode
      skew = 4'h0;
      single = 1'b1;
      repeat (32) @(posedge clk_i);
      #1;
      foreach (addrs[i]) rd(addrs[i]);
      drain();
      single = 1'b0;
      // Reset with a read in flight
      rd(19'h00000);
      rstn_i = 1'b0;
      u_dss_ctl.idle();
      chk("reset outputs", '0, dss_cmp_t'({q_oe, echo, echo_n, q}));
      exp_q.delete();
      rstn_i = 1'b1;
      repeat (16) @(posedge clk_i);
      #1;
      u_dss_ctl.got_q.delete();
      rd(19'h00000);
      drain();
      chk("echo errors", '0, dss_cmp_t'(u_dss_ctl.echo_errs));
      end_sim();
   end
endmodule
